// *** inc/pkt_buffer_diag_pkg.sv ***
// Package with the map, field layouts, reset values and types of the packet buffer diagnostic bank.
package pkt_buffer_diag_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int ADDR_W   = 17;
  localparam int DATA_W   = 32;
  localparam int STRB_W   = 4;
  localparam int PTR_W    = 13;
  localparam int SIZE_W   = 6;
  localparam int RAM_AW   = 14;
  localparam int WIN_AW   = 13;

  // ---------------------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_BUFFER_TOTAL_SIZE    = 17'h01008;
  localparam logic [ADDR_W-1:0] OFS_RX_FIFO_PACKET_COUNT = 17'h02430;
  localparam logic [ADDR_W-1:0] OFS_TX_FIFO_HEAD_POINTER = 17'h03410;
  localparam logic [ADDR_W-1:0] OFS_TX_FIFO_TAIL_POINTER = 17'h03418;
  localparam logic [ADDR_W-1:0] OFS_TX_FIFO_HEAD_SAVED   = 17'h03420;
  localparam logic [ADDR_W-1:0] OFS_TX_FIFO_TAIL_SAVED   = 17'h03428;
  localparam logic [ADDR_W-1:0] OFS_TX_FIFO_PACKET_COUNT = 17'h03430;
  localparam logic [ADDR_W-1:0] OFS_TX_HEAD_ALIAS        = 17'h08010;
  localparam logic [ADDR_W-1:0] OFS_TX_TAIL_ALIAS        = 17'h08018;
  localparam logic [ADDR_W-1:0] OFS_WINDOW_FIRST         = 17'h10000;
  localparam logic [ADDR_W-1:0] OFS_WINDOW_LAST          = 17'h17FFF;

  // ---------------------------------------------------------------------------
  // Reset values and sizes
  // ---------------------------------------------------------------------------
  localparam logic [PTR_W-1:0]  TX_PTR_RESET   = 13'h0600;
  localparam logic [PTR_W-1:0]  PKT_CNT_RESET  = 13'h0000;
  localparam logic [SIZE_W-1:0] SIZE_RESET     = 6'h28;
  localparam int                QWORD_KB_SHIFT = 7;
  localparam int                BUFFER_KB      = 40;
  localparam int                RAM_WORDS      = BUFFER_KB * 1024 / 4;
  localparam logic [DATA_W-1:0] UNMAPPED_DATA  = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b11
  } apb_state_t;

  typedef enum logic [3:0] {
    SEL_NONE  = 4'h0,
    SEL_SIZE  = 4'h1,
    SEL_RXCNT = 4'h2,
    SEL_HEAD  = 4'h3,
    SEL_TAIL  = 4'h4,
    SEL_HSAV  = 4'h5,
    SEL_TSAV  = 4'h6,
    SEL_TXCNT = 4'h7,
    SEL_MEM   = 4'h8
  } reg_sel_t;

  typedef struct packed {
    logic [PTR_W-1:0] head;
    logic [PTR_W-1:0] tail;
    logic [PTR_W-1:0] head_saved;
    logic [PTR_W-1:0] tail_saved;
  } tx_ptrs_t;

  typedef struct packed {
    logic             rd_en;
    logic [STRB_W-1:0] wr_strb;
    logic [RAM_AW-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ram_req_t;

endpackage

// *** design/pkt_buffer_ram.sv ***
// Packet buffer storage: 32-bit words with byte enables and a registered read port.
`timescale 1ns/1ps
module pkt_buffer_ram
  import pkt_buffer_diag_pkg::*;
(
  input  wire logic              mclk,
  input  wire ram_req_t          req,
  output logic      [DATA_W-1:0] rdata
);

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------

  // Each byte lane keeps its own array so partial writes keep the other lanes.
  genvar lane;
  generate
    for (lane = 0; lane < STRB_W; lane++) begin : g_lane
      logic [7:0] mem [RAM_WORDS];
      logic [7:0] q_ff;

      assign rdata[lane*8 +: 8] = q_ff;

      always_ff @(posedge mclk) begin
        if (req.wr_strb[lane]) begin
          mem[req.addr] <= req.wdata[lane*8 +: 8];
        end
      end

      always_ff @(posedge mclk) begin
        if (req.rd_en) begin
          q_ff <= mem[req.addr];
        end
      end
    end
  endgenerate

endmodule

// *** design/pkt_buffer_diag_regs.sv ***
// APB register bank for packet buffer diagnostics: FIFO pointers, packet counts, buffer window.
//
// Functional notes
// - Receive packet count register reports received packets in FIFO, 13-bit field.
// - Transmit packet count register reports packets awaiting transmission, 13-bit field.
// - All four transmit pointer fields reset to 0x600, receive allocation times 128.
// - Pointers count 64-bit words; value 0x8 means byte offset 64.
// - Transmit head pointer also answers at alias offset 0x08010.
// - Transmit tail pointer also answers at alias offset 0x08018.
// - Transmit pointers are offsets from start of whole buffer, not transmit region.
// - Saved head and tail hold copies of live pointers for later restore.
// - Bits above the 13-bit field read zero; software writes them as zero.
// - Buffer contents read/write through window 0x10000 to 0x17FFF, 32/64-bit accesses.
// - Buffer totals 40 KB; default split 28 KB transmit, 12 KB receive.
// - Receive region sits low; default receive ends 0x12FFF, transmit starts 0x13000.
// - Size register low six bits writable in 1 KB units, reset 0x0028.
// - Writing the size register does not reload any buffer pointers.
// - Size register survives global software reset, returns to 0x0028 only on power-on reset.
`timescale 1ns/1ps
module pkt_buffer_diag_regs
  import pkt_buffer_diag_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              soft_rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [STRB_W-1:0] pstrb,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rx_pkt_push,
  input  wire logic              rx_pkt_pop,
  input  wire logic              tx_pkt_push,
  input  wire logic              tx_pkt_pop,
  input  wire logic              tx_head_adv,
  input  wire logic              tx_tail_adv,
  input  wire logic              tx_ptr_save,
  input  wire logic              tx_ptr_restore,
  output logic      [PTR_W-1:0]  tx_head_ptr,
  output logic      [PTR_W-1:0]  tx_tail_ptr,
  output logic      [SIZE_W-1:0] buf_size_kb
);

  // ---------------------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------------------

  // Maps a byte address onto the register or window it selects.
  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    if (addr[1:0] != 2'b00) begin
      sel = SEL_NONE;
    end else if (addr >= OFS_WINDOW_FIRST && addr <= OFS_WINDOW_LAST) begin
      sel = SEL_MEM;
    end else begin
      case (addr)
        OFS_BUFFER_TOTAL_SIZE:    sel = SEL_SIZE;
        OFS_RX_FIFO_PACKET_COUNT: sel = SEL_RXCNT;
        OFS_TX_FIFO_HEAD_POINTER: sel = SEL_HEAD;
        OFS_TX_HEAD_ALIAS:        sel = SEL_HEAD;
        OFS_TX_FIFO_TAIL_POINTER: sel = SEL_TAIL;
        OFS_TX_TAIL_ALIAS:        sel = SEL_TAIL;
        OFS_TX_FIFO_HEAD_SAVED:   sel = SEL_HSAV;
        OFS_TX_FIFO_TAIL_SAVED:   sel = SEL_TSAV;
        OFS_TX_FIFO_PACKET_COUNT: sel = SEL_TXCNT;
        default:                  sel = SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  // Merges a write into a 13-bit field; bits above it are dropped.
  function automatic logic [PTR_W-1:0] merge13(
    input logic [PTR_W-1:0]  old_val,
    input logic [DATA_W-1:0] wdata,
    input logic [STRB_W-1:0] strb
  );
    logic [PTR_W-1:0] res;
    res = old_val;
    if (strb[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (strb[1]) begin
      res[PTR_W-1:8] = wdata[PTR_W-1:8];
    end
    return res;
  endfunction

  // Zero-extends a 13-bit field to a bus word.
  function automatic logic [DATA_W-1:0] field13(input logic [PTR_W-1:0] val);
    return {{(DATA_W-PTR_W){1'b0}}, val};
  endfunction

  // Steps a pointer by one quadword and wraps at the configured buffer end.
  function automatic logic [PTR_W-1:0] step_ptr(
    input logic [PTR_W-1:0]  ptr,
    input logic [SIZE_W-1:0] size_kb
  );
    logic [PTR_W-1:0] last;
    last = PTR_W'({size_kb, {QWORD_KB_SHIFT{1'b0}}} - 1);
    if (ptr >= last) begin
      return TX_PTR_RESET;
    end
    return ptr + PTR_W'(1);
  endfunction

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  apb_state_t        state_ff;
  apb_state_t        nxt_state;
  logic [DATA_W-1:0] prdata_ff;
  logic [DATA_W-1:0] nxt_prdata;
  logic              pready_ff;
  logic              pslverr_ff;
  logic [SIZE_W-1:0] size_ff;
  tx_ptrs_t          ptrs_ff;
  tx_ptrs_t          nxt_ptrs;
  logic [PTR_W-1:0]  cnt_ff [2];
  logic [1:0]        cnt_push;
  logic [1:0]        cnt_pop;
  logic [1:0]        cnt_wr;
  reg_sel_t          sel;
  logic              setup_cyc;
  logic              wr_fire;
  ram_req_t          ram_req;
  logic [DATA_W-1:0] ram_rdata;

  assign prdata      = prdata_ff;
  assign pready      = pready_ff;
  assign pslverr     = pslverr_ff;
  assign tx_head_ptr = ptrs_ff.head;
  assign tx_tail_ptr = ptrs_ff.tail;
  assign buf_size_kb = size_ff;

  assign sel       = decode(paddr);
  assign setup_cyc = psel && !penable && (state_ff == ST_IDLE);
  assign wr_fire   = psel && penable && pwrite && (state_ff == ST_DONE);

  // ---------------------------------------------------------------------------
  // APB handshake
  // ---------------------------------------------------------------------------

  // Every access takes one wait state: the window read needs the RAM cycle.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (psel && !penable) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (psel && penable) begin
          nxt_state = ST_DONE;
        end else if (!psel) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_DONE: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= (state_ff == ST_WAIT) && psel && penable;
      pslverr_ff <= (state_ff == ST_WAIT) && psel && penable && (sel == SEL_NONE);
    end
  end

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_prdata = UNMAPPED_DATA;
    case (sel)
      SEL_SIZE:  nxt_prdata = {{(DATA_W-SIZE_W){1'b0}}, size_ff};
      SEL_RXCNT: nxt_prdata = field13(cnt_ff[0]);
      SEL_HEAD:  nxt_prdata = field13(ptrs_ff.head);
      SEL_TAIL:  nxt_prdata = field13(ptrs_ff.tail);
      SEL_HSAV:  nxt_prdata = field13(ptrs_ff.head_saved);
      SEL_TSAV:  nxt_prdata = field13(ptrs_ff.tail_saved);
      SEL_TXCNT: nxt_prdata = field13(cnt_ff[1]);
      SEL_MEM:   nxt_prdata = ram_rdata;
      default:   nxt_prdata = UNMAPPED_DATA;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata_ff <= UNMAPPED_DATA;
    end else if ((state_ff == ST_WAIT) && psel && penable && !pwrite) begin
      prdata_ff <= nxt_prdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Buffer size
  // ---------------------------------------------------------------------------

  // Only power-on reset returns the size to its default; soft reset leaves it.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      size_ff <= SIZE_RESET;
    end else if (wr_fire && (sel == SEL_SIZE) && pstrb[0]) begin
      size_ff <= pwdata[SIZE_W-1:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Transmit pointers
  // ---------------------------------------------------------------------------

  // Software writes win over restore, save and advance in the same cycle.
  // A size write touches none of these pointers.
  always_comb begin
    nxt_ptrs = ptrs_ff;
    if (tx_ptr_restore) begin
      nxt_ptrs.head = ptrs_ff.head_saved;
      nxt_ptrs.tail = ptrs_ff.tail_saved;
    end else begin
      if (tx_head_adv) begin
        nxt_ptrs.head = step_ptr(ptrs_ff.head, size_ff);
      end
      if (tx_tail_adv) begin
        nxt_ptrs.tail = step_ptr(ptrs_ff.tail, size_ff);
      end
    end
    if (tx_ptr_save) begin
      nxt_ptrs.head_saved = ptrs_ff.head;
      nxt_ptrs.tail_saved = ptrs_ff.tail;
    end
    if (wr_fire) begin
      case (sel)
        SEL_HEAD: nxt_ptrs.head = merge13(ptrs_ff.head, pwdata, pstrb);
        SEL_TAIL: nxt_ptrs.tail = merge13(ptrs_ff.tail, pwdata, pstrb);
        SEL_HSAV: nxt_ptrs.head_saved = merge13(ptrs_ff.head_saved, pwdata, pstrb);
        SEL_TSAV: nxt_ptrs.tail_saved = merge13(ptrs_ff.tail_saved, pwdata, pstrb);
        default:  nxt_ptrs = nxt_ptrs;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ptrs_ff <= '{TX_PTR_RESET, TX_PTR_RESET, TX_PTR_RESET, TX_PTR_RESET};
    end else if (soft_rst) begin
      ptrs_ff <= '{TX_PTR_RESET, TX_PTR_RESET, TX_PTR_RESET, TX_PTR_RESET};
    end else begin
      ptrs_ff <= nxt_ptrs;
    end
  end

  // ---------------------------------------------------------------------------
  // Packet counters
  // ---------------------------------------------------------------------------

  // Index 0 counts receive packets, index 1 transmit packets.
  assign cnt_push = {tx_pkt_push, rx_pkt_push};
  assign cnt_pop  = {tx_pkt_pop, rx_pkt_pop};
  assign cnt_wr   = {wr_fire && (sel == SEL_TXCNT), wr_fire && (sel == SEL_RXCNT)};

  genvar ci;
  generate
    for (ci = 0; ci < 2; ci++) begin : g_cnt
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          cnt_ff[ci] <= PKT_CNT_RESET;
        end else if (soft_rst) begin
          cnt_ff[ci] <= PKT_CNT_RESET;
        end else if (cnt_wr[ci]) begin
          cnt_ff[ci] <= merge13(cnt_ff[ci], pwdata, pstrb);
        end else if (cnt_push[ci] && !cnt_pop[ci]) begin
          cnt_ff[ci] <= cnt_ff[ci] + PTR_W'(1);
        end else if (cnt_pop[ci] && !cnt_push[ci] && (cnt_ff[ci] != PKT_CNT_RESET)) begin
          cnt_ff[ci] <= cnt_ff[ci] - PTR_W'(1);
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Buffer window
  // ---------------------------------------------------------------------------

  // The window starts at buffer word 0, so the receive region shows first.
  always_comb begin
    ram_req.addr    = {1'b0, paddr[WIN_AW+1:2]};
    ram_req.wdata   = pwdata;
    ram_req.rd_en   = setup_cyc && !pwrite && (sel == SEL_MEM);
    ram_req.wr_strb = (wr_fire && (sel == SEL_MEM)) ? pstrb : '0;
  end

  // Storage sized for the whole 40 KB buffer.
  pkt_buffer_ram u_ram (
    .mclk  (mclk),
    .req   (ram_req),
    .rdata (ram_rdata)
  );

endmodule

// *** tb/pkt_buffer_diag_properties.sv ***
// Concurrent checks on the ports of the packet buffer diagnostic bank.
`timescale 1ns/1ps
module pkt_buffer_diag_properties
  import pkt_buffer_diag_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic              soft_rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [STRB_W-1:0] pstrb,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              tx_head_adv,
  input wire logic              tx_tail_adv,
  input wire logic              tx_ptr_save,
  input wire logic              tx_ptr_restore,
  input wire logic [PTR_W-1:0]  tx_head_ptr,
  input wire logic [PTR_W-1:0]  tx_tail_ptr,
  input wire logic [SIZE_W-1:0] buf_size_kb
);
  // ----------
  // Checks
  // ----------
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire quiet = !soft_rst && !(psel && pwrite);

  a_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_upper_zero: assert property (pready && !pwrite && paddr < OFS_WINDOW_FIRST
    |-> prdata[31:13] == 19'h0) else $error("upper read bits not zero");
  a_soft_ptrs: assert property (soft_rst |=> tx_head_ptr == TX_PTR_RESET
    && tx_tail_ptr == TX_PTR_RESET) else $error("pointers not reset by soft reset");
  a_size_kept: assert property (soft_rst && !psel |=> $stable(buf_size_kb))
    else $error("size changed by soft reset");
  a_size_no_ptr: assert property (pready && pwrite && paddr == OFS_BUFFER_TOTAL_SIZE
    && !soft_rst && !tx_head_adv && !tx_tail_adv && !tx_ptr_restore
    |=> $stable(tx_head_ptr) && $stable(tx_tail_ptr)) else $error("size write moved pointers");
  a_head_step: assert property (quiet && tx_head_adv && !tx_ptr_restore
    && 32'(tx_head_ptr) < 32'(buf_size_kb) * 128 - 1
    |=> tx_head_ptr == $past(tx_head_ptr) + 13'h1) else $error("head did not step by one");
  a_save_restore: assert property ((quiet && tx_ptr_save) ##1 (quiet && tx_ptr_restore)
    |=> tx_head_ptr == $past(tx_head_ptr, 2) && tx_tail_ptr == $past(tx_tail_ptr, 2))
    else $error("restore did not return saved pointers");
  a_alias_head: assert property (pready && pwrite && !pslverr && !soft_rst
    && paddr == OFS_TX_HEAD_ALIAS && pstrb == 4'hF
    |=> {19'h0, tx_head_ptr} == ($past(pwdata) & 32'h0000_1FFF))
    else $error("alias write did not reach head");
endmodule

bind pkt_buffer_diag_regs pkt_buffer_diag_properties u_props (
  .mclk(mclk), .rst(rst), .soft_rst(soft_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tx_head_adv(tx_head_adv), .tx_tail_adv(tx_tail_adv),
  .tx_ptr_save(tx_ptr_save), .tx_ptr_restore(tx_ptr_restore), .tx_head_ptr(tx_head_ptr),
  .tx_tail_ptr(tx_tail_ptr), .buf_size_kb(buf_size_kb)
);

// *** tb/pkt_buffer_diag_regs_tb.sv ***
// Self-checking bench for the packet buffer diagnostic bank.
`timescale 1ns/1ps
module pkt_buffer_diag_regs_tb
  import pkt_buffer_diag_pkg::*;
;
  typedef struct packed {
    logic [ADDR_W-1:0] wa;
    logic [DATA_W-1:0] wd;
    logic [ADDR_W-1:0] ra;
    logic [DATA_W-1:0] ex;
  } row_t;

  logic              mclk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [STRB_W-1:0] pstrb;
  logic [8:0]        ev;
  logic [PTR_W-1:0]  head, tail;
  logic [SIZE_W-1:0] size;
  int                bad_count, total_checks;
  row_t              rows [12];
  logic [ADDR_W-1:0] dflt_a [7];
  logic [DATA_W-1:0] dflt_e [7];

  pkt_buffer_diag_regs dut (
    .mclk(mclk), .rst(rst), .soft_rst(ev[8]), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_pkt_push(ev[0]), .rx_pkt_pop(ev[1]),
    .tx_pkt_push(ev[2]), .tx_pkt_pop(ev[3]), .tx_head_adv(ev[4]), .tx_tail_adv(ev[5]),
    .tx_ptr_save(ev[6]), .tx_ptr_restore(ev[7]), .tx_head_ptr(head), .tx_tail_ptr(tail),
    .buf_size_kb(size)
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ----------
  // Tasks
  // ----------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      bad_count++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    xfer(1'b0, a, '0);
    chk(rd, e);
  endtask

  task automatic pulse(input int b, input int n);
    repeat (n) begin
      ev[b] <= 1'b1;
      @(posedge mclk);
      ev[b] <= 1'b0;
      @(posedge mclk);
    end
  endtask

  // ----------
  // Sequence
  // ----------
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    ev = '0;
    bad_count = 0;
    total_checks = 0;
    rows = '{
      '{OFS_BUFFER_TOTAL_SIZE, 32'hFFFF_FFE5, OFS_BUFFER_TOTAL_SIZE, 32'h0000_0025},
      '{OFS_RX_FIFO_PACKET_COUNT, 32'hFFFF_F234, OFS_RX_FIFO_PACKET_COUNT, 32'h0000_1234},
      '{OFS_TX_FIFO_HEAD_POINTER, 32'hFFFF_EA10, OFS_TX_FIFO_HEAD_POINTER, 32'h0000_0A10},
      '{OFS_TX_FIFO_TAIL_POINTER, 32'h0000_0C20, OFS_TX_FIFO_TAIL_POINTER, 32'h0000_0C20},
      '{OFS_TX_FIFO_HEAD_SAVED, 32'hFFFF_FFFF, OFS_TX_FIFO_HEAD_SAVED, 32'h0000_1FFF},
      '{OFS_TX_FIFO_TAIL_SAVED, 32'h0000_0001, OFS_TX_FIFO_TAIL_SAVED, 32'h0000_0001},
      '{OFS_TX_FIFO_PACKET_COUNT, 32'h0000_0002, OFS_TX_FIFO_PACKET_COUNT, 32'h0000_0002},
      '{OFS_TX_HEAD_ALIAS, 32'h0000_0700, OFS_TX_FIFO_HEAD_POINTER, 32'h0000_0700},
      '{OFS_TX_FIFO_TAIL_POINTER, 32'h0000_0740, OFS_TX_TAIL_ALIAS, 32'h0000_0740},
      '{17'h10000, 32'hDEAD_BEEF, 17'h10000, 32'hDEAD_BEEF},
      '{17'h14000, 32'h0BAD_F00D, 17'h14000, 32'h0BAD_F00D},
      '{17'h17FFC, 32'h1234_5678, 17'h17FFC, 32'h1234_5678}};
    dflt_a = '{OFS_BUFFER_TOTAL_SIZE, OFS_RX_FIFO_PACKET_COUNT, OFS_TX_FIFO_HEAD_POINTER,
      OFS_TX_FIFO_TAIL_POINTER, OFS_TX_FIFO_HEAD_SAVED, OFS_TX_FIFO_TAIL_SAVED,
      OFS_TX_FIFO_PACKET_COUNT};
    dflt_e = '{32'h28, 32'h0, 32'h600, 32'h600, 32'h600, 32'h600, 32'h0};
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      xfer(1'b1, rows[i].wa, rows[i].wd);
      rdchk(rows[i].ra, rows[i].ex);
    end
    chk({19'h0, head}, 32'h0000_0700);
    chk({19'h0, tail}, 32'h0000_0740);
    done("table");
    xfer(1'b0, 17'h18000, '0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    xfer(1'b1, 17'h03412, 32'h0000_0123);
    chk({31'h0, err}, 32'h1);
    rdchk(OFS_TX_FIFO_HEAD_POINTER, 32'h0000_0700);
    done("refused");
    xfer(1'b1, OFS_BUFFER_TOTAL_SIZE, 32'h0000_0020);
    @(posedge mclk);
    chk({19'h0, head}, 32'h0000_0700);
    chk({26'h0, size}, 32'h0000_0020);
    pulse(8, 1);
    rdchk(OFS_BUFFER_TOTAL_SIZE, 32'h0000_0020);
    rdchk(OFS_TX_FIFO_HEAD_SAVED, 32'h0000_0600);
    rdchk(OFS_RX_FIFO_PACKET_COUNT, 32'h0);
    done("soft reset");
    pulse(0, 3);
    pulse(1, 1);
    rdchk(OFS_RX_FIFO_PACKET_COUNT, 32'h2);
    pulse(3, 1);
    pulse(2, 2);
    rdchk(OFS_TX_FIFO_PACKET_COUNT, 32'h2);
    done("counts");
    pulse(4, 8);
    chk({19'h0, head}, 32'h0000_0608);
    pulse(5, 2);
    ev[6] <= 1'b1;
    @(posedge mclk);
    ev[6] <= 1'b0;
    ev[7] <= 1'b1;
    @(posedge mclk);
    ev[7] <= 1'b0;
    @(posedge mclk);
    pulse(4, 3);
    chk({19'h0, head}, 32'h0000_060B);
    pulse(7, 1);
    chk({19'h0, head}, 32'h0000_0608);
    chk({19'h0, tail}, 32'h0000_0602);
    rdchk(OFS_TX_FIFO_TAIL_SAVED, 32'h0000_0602);
    done("pointers");
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    foreach (dflt_a[i]) begin
      rdchk(dflt_a[i], dflt_e[i]);
    end
    done("power-on reset");
    end_of_test();
  end
endmodule
